// ### common/rstc_pkg.sv
// Package with constants and carriers for the reset source and trim word block
package rstc_pkg;
    // ----------------------------------------
    // Trim word location and layout
    // ----------------------------------------
    localparam logic [13:0] RSTC_TRIM_ADDR = 14'h2008;
    localparam logic [13:0] RSTC_CFG_LO = 14'h2000;
    localparam logic [13:0] RSTC_CFG_HI = 14'h3FFF;
    localparam int RSTC_TRIM_W = 14;
    localparam int RSTC_OSC_LSB = 6;
    localparam int RSTC_POR_LSB = 3;
    localparam int RSTC_BOD_LSB = 0;
    localparam logic [13:0] RSTC_TRIM_RST = 14'h0000;
    // Synchroniser reset: pin bit (bit 3) idles high
    localparam logic [5:0] RSTC_SYNC_RST = 6'h08;
    // ----------------------------------------
    // Glitch filter timing
    // ----------------------------------------
    localparam int RSTC_FILT_NS = 2000;
    localparam int RSTC_CLK_NS = 25;
    localparam int RSTC_FILT_CYC = (RSTC_FILT_NS + RSTC_CLK_NS - 1) / RSTC_CLK_NS;
    localparam logic [7:0] RSTC_FILT_MAX = 8'(RSTC_FILT_CYC);

    typedef enum logic [2:0] {
        RSTC_CAUSE_NONE,
        RSTC_CAUSE_POR,
        RSTC_CAUSE_WDT_RUN,
        RSTC_CAUSE_WDT_SLEEP,
        RSTC_CAUSE_PIN_RUN,
        RSTC_CAUSE_PIN_SLEEP,
        RSTC_CAUSE_BOD
    } rstc_cause_e;

    typedef struct packed {
        logic [6:0] osc_freq_trim;
        logic [1:0] por_threshold_trim;
        logic [2:0] brownout_threshold_trim;
    } rstc_trim_s;

    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
    } rstc_flags_s;
endpackage

// ### rtl/rstc_core.sv
// Reset cause logic, pin filter and factory trim word storage
// Notes on behaviour
// - One trim word keeps the brown-out, power-on and oscillator factory values.
// - The trim word sits at configuration address 2008h.
// - Configuration space 2000h to 3FFFh answers only in programming mode.
// - A device erase leaves the trim word untouched.
// - Six reset causes are told apart.
// - Some registers are never reset and keep their value over all resets.
// - Most registers reset on power-on, pin, watchdog and brown-out resets.
// - A watchdog wake-up from sleep loads no reset values.
// - Timeout and power-down flags follow the reset cause.
// - Short glitches on the reset pin are filtered out.
// - Power-on detect holds reset until the supply is good.
// - With brown-out detect enabled, reset holds until the threshold is met.
// - A watchdog reset never drives the reset pin low.
// - With the pin option cleared, reset is tied inactive and a pull-up is on.
// - The pin option does not affect serial programming.
`timescale 1ns/1ps
module rstc_core (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic supply_ok_in,
    input wire logic brownout_ok_in,
    input wire logic brownout_detect_en_in,
    input wire logic external_reset_pin_in,
    input wire logic external_reset_pin_select_in,
    input wire logic watchdog_timeout_in,
    input wire logic sleep_in,
    input wire logic prog_mode_in,
    input wire logic [13:0] prog_addr_in,
    input wire logic prog_rd_in,
    input wire logic prog_trim_wr_in,
    input wire logic prog_erase_in,
    input wire logic [13:0] prog_wdata_in,
    output logic [13:0] prog_rdata_out,
    output logic prog_rvalid_out,
    output rstc_pkg::rstc_trim_s trim_out,
    output rstc_pkg::rstc_flags_s flags_out,
    output rstc_pkg::rstc_cause_e cause_out,
    output logic core_reset_out,
    output logic wake_out,
    output logic pin_pullup_en_out,
    output logic pin_drive_out,
    output logic pin_drive_en_out
);
    import rstc_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Supply, brown-out, pin, watchdog, sleep and mode, msb first
    logic [5:0] sync_raw;
    logic [5:0] sync1_q;
    logic [5:0] sync1_d;
    logic [5:0] sync2_q;
    logic [5:0] sync2_d;
    always_comb begin
        sync_raw = {supply_ok_in, brownout_ok_in, external_reset_pin_in,
                    watchdog_timeout_in, sleep_in, prog_mode_in};
        sync1_d = sync_raw;
        // Only the second stage is read by logic
        sync2_d = sync1_q;
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // Pin bit idles high so the filter sees no false press
            sync1_q <= RSTC_SYNC_RST;
            sync2_q <= RSTC_SYNC_RST;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    logic supply_ok;
    logic bod_ok;
    logic pin_raw;
    logic wdt_to;
    logic asleep;
    logic prog_mode;
    assign supply_ok = sync2_q[5];
    assign bod_ok = sync2_q[4];
    assign pin_raw = sync2_q[3];
    assign wdt_to = sync2_q[2];
    assign asleep = sync2_q[1];
    assign prog_mode = sync2_q[0];

    // ----------------------------------------
    // Pin glitch filter
    // ----------------------------------------
    logic pin_lvl;
    logic [7:0] filt_cnt_q, filt_cnt_d;
    logic pin_filt_q, pin_filt_d;
    always_comb begin
        // Tied inactive when the pin option is cleared
        pin_lvl = external_reset_pin_select_in ? pin_raw : 1'b1;
        filt_cnt_d = 8'h00;
        pin_filt_d = pin_filt_q;
        if (pin_lvl != pin_filt_q) begin
            if (filt_cnt_q == RSTC_FILT_MAX - 8'h01) begin
                pin_filt_d = pin_lvl;
            end else begin
                filt_cnt_d = filt_cnt_q + 8'h01;
            end
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            filt_cnt_q <= 8'h00;
            pin_filt_q <= 1'b1;
        end else begin
            filt_cnt_q <= filt_cnt_d;
            pin_filt_q <= pin_filt_d;
        end
    end

    // ----------------------------------------
    // Core reset request
    // ----------------------------------------
    logic rst_q;
    logic rst_d;
    logic hold;
    logic bod_low;
    always_comb begin
        bod_low = brownout_detect_en_in && !bod_ok;
        hold = !supply_ok || bod_low;
        // Watchdog reset stays internal; pin never driven
        rst_d = hold || !pin_filt_q || (wdt_to && !asleep);
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        // Core held in reset while the async reset is low
        if (!arst_n_in) begin
            rst_q <= 1'b1;
        end else begin
            rst_q <= rst_d;
        end
    end

    // ----------------------------------------
    // Reset cause and flags
    // ----------------------------------------
    logic por_q;
    logic por_d;
    logic wake_q;
    logic wake_d;
    rstc_cause_e cause_q;
    rstc_cause_e cause_d;
    rstc_flags_s flags_q;
    rstc_flags_s flags_d;
    always_comb begin
        por_d = por_q;
        cause_d = cause_q;
        flags_d = flags_q;
        wake_d = 1'b0;
        if (!supply_ok) begin
            // Power-on restarts the episode
            por_d = 1'b1;
            cause_d = RSTC_CAUSE_POR;
            flags_d.timeout_flag = 1'b1;
            flags_d.powerdown_flag = 1'b1;
        end else if (bod_low) begin
            // A brown-out inside a power-on episode stays a power-on
            if (!por_q) begin
                cause_d = RSTC_CAUSE_BOD;
                flags_d.timeout_flag = 1'b1;
                flags_d.powerdown_flag = 1'b1;
            end
        end else if (!pin_filt_q) begin
            // Cause latched once per reset episode
            if (!rst_q) begin
                cause_d = asleep ? RSTC_CAUSE_PIN_SLEEP : RSTC_CAUSE_PIN_RUN;
                if (asleep) begin
                    flags_d.timeout_flag = 1'b1;
                    flags_d.powerdown_flag = 1'b0;
                end
            end
        end else if (wdt_to && !rst_q) begin
            flags_d.timeout_flag = 1'b0;
            if (asleep) begin
                // Wake-up resumes execution, no register reset
                cause_d = RSTC_CAUSE_WDT_SLEEP;
                flags_d.powerdown_flag = 1'b0;
                wake_d = 1'b1;
            end else begin
                cause_d = RSTC_CAUSE_WDT_RUN;
            end
        end else begin
            // Supply good and no request: episode over
            por_d = 1'b0;
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            por_q <= 1'b1;
            wake_q <= 1'b0;
            cause_q <= RSTC_CAUSE_POR;
            flags_q <= '{timeout_flag: 1'b1, powerdown_flag: 1'b1};
        end else begin
            por_q <= por_d;
            wake_q <= wake_d;
            cause_q <= cause_d;
            flags_q <= flags_d;
        end
    end

    // ----------------------------------------
    // Trim word, reachable only when programming
    // ----------------------------------------
    // Never cleared by any reset cause or erase
    logic [13:0] trim_q;
    logic [13:0] trim_d;
    logic [13:0] rdata_q;
    logic [13:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic in_cfg;
    logic at_trim;
    logic trim_wr;
    always_comb begin
        in_cfg = prog_addr_in >= RSTC_CFG_LO && prog_addr_in <= RSTC_CFG_HI;
        at_trim = prog_addr_in == RSTC_TRIM_ADDR;
        // Erase held with a write blocks the write
        trim_wr = prog_trim_wr_in && at_trim && !prog_erase_in;
        trim_d = trim_q;
        rdata_d = 14'h0000;
        rvalid_d = 1'b0;
        // Serial programming path ignores the pin option
        if (prog_mode && in_cfg) begin
            if (trim_wr) begin
                trim_d = prog_wdata_in;
                // Unused bits always read zero
                trim_d[13] = 1'b0;
                trim_d[5] = 1'b0;
            end
            if (prog_rd_in) begin
                rvalid_d = 1'b1;
                // Other configuration words read zero
                rdata_d = at_trim ? trim_q : 14'h0000;
            end
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_q <= 14'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end
    always_ff @(posedge clk_in) begin
        trim_q <= trim_d;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic pullup_q;
    logic pullup_d;
    logic drive_q;
    logic drive_d;
    logic drive_en_q;
    logic drive_en_d;
    always_comb begin
        pullup_d = !external_reset_pin_select_in;
        // Pin stays an input; no reset cause ever pulls it low
        drive_d = 1'b0;
        drive_en_d = 1'b0;
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pullup_q <= 1'b0;
            drive_q <= 1'b0;
            drive_en_q <= 1'b0;
        end else begin
            pullup_q <= pullup_d;
            drive_q <= drive_d;
            drive_en_q <= drive_en_d;
        end
    end

    // Trim fields unpacked at their stored positions
    logic [6:0] osc_field;
    logic [1:0] por_field;
    logic [2:0] bod_field;
    assign osc_field = trim_q[RSTC_OSC_LSB +: 7];
    assign por_field = trim_q[RSTC_POR_LSB +: 2];
    assign bod_field = trim_q[RSTC_BOD_LSB +: 3];

    assign prog_rdata_out = rdata_q;
    assign prog_rvalid_out = rvalid_q;
    assign trim_out = '{osc_freq_trim: osc_field, por_threshold_trim: por_field,
                        brownout_threshold_trim: bod_field};
    assign flags_out = flags_q;
    assign cause_out = cause_q;
    assign core_reset_out = rst_q;
    assign wake_out = wake_q;
    assign pin_pullup_en_out = pullup_q;
    assign pin_drive_out = drive_q;
    assign pin_drive_en_out = drive_en_q;
endmodule

// ### dv/rstc_core_assertions.sv
// Checker for the reset source and trim word block
`timescale 1ns/1ps
module rstc_core_assertions
    import rstc_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic supply_ok_in,
    input wire logic brownout_ok_in,
    input wire logic brownout_detect_en_in,
    input wire logic external_reset_pin_select_in,
    input wire logic [13:0] prog_addr_in,
    input wire logic prog_rd_in,
    input wire logic prog_erase_in,
    input wire logic [13:0] prog_rdata_out,
    input wire logic prog_rvalid_out,
    input wire rstc_trim_s trim_out,
    input wire rstc_flags_s flags_out,
    input wire logic core_reset_out,
    input wire logic wake_out,
    input wire logic pin_pullup_en_out,
    input wire logic pin_drive_en_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    a_pin_released: assert property (!pin_drive_en_out) else $error("pin driven");
    a_pullup_follows: assert property (1'b1 |=>
        pin_pullup_en_out == !$past(external_reset_pin_select_in)) else $error("pull-up");
    a_read_cfg_only: assert property (prog_rvalid_out |->
        $past(prog_rd_in && prog_addr_in[13])) else $error("read outside space");
    a_read_trim_word: assert property (prog_rvalid_out && $past(prog_addr_in) == RSTC_TRIM_ADDR
        |-> prog_rdata_out == {1'b0, $past(trim_out[11:5]), 1'b0, $past(trim_out[4:0])})
        else $error("trim read data");
    a_erase_keeps_trim: assert property (prog_erase_in |=> $stable(trim_out))
        else $error("trim erased");
    a_wake_flags_clear: assert property (wake_out |-> ##[0:2] flags_out == 2'b00)
        else $error("wake flags");
    a_supply_holds: assert property (!supply_ok_in |-> ##[0:4] core_reset_out)
        else $error("no power-on hold");
    a_brownout_holds: assert property (brownout_detect_en_in && !brownout_ok_in
        |-> ##[0:4] core_reset_out) else $error("no brown-out hold");
    c_read: cover property (prog_rvalid_out);
    c_wake: cover property (wake_out);
    c_reset: cover property ($rose(core_reset_out));
endmodule

bind rstc_core rstc_core_assertions u_chk (.clk_in, .arst_n_in, .supply_ok_in,
    .brownout_ok_in, .brownout_detect_en_in, .external_reset_pin_select_in,
    .prog_addr_in, .prog_rd_in, .prog_erase_in, .prog_rdata_out, .prog_rvalid_out,
    .trim_out, .flags_out, .core_reset_out, .wake_out, .pin_pullup_en_out,
    .pin_drive_en_out);

// ### dv/rstc_pin_model.sv
// Model of the outside driver of the reset pin
`timescale 1ns/1ps
module rstc_pin_model (
    input wire logic supply_ok_in,
    output logic pin_out
);
    logic pressed = 1'b0;
    // Low while pressed or while supply is not good
    assign pin_out = !(pressed || !supply_ok_in);
    task press(input logic v);
        pressed = v;
    endtask
endmodule

// ### dv/rstc_core_test.sv
// Self-checking bench for the reset source and trim word block
`timescale 1ns/1ps
module rstc_core_test;
    import rstc_pkg::*;
    logic clk_in = 1'b0, arst_n_in = 1'b0, supply_ok_in = 1'b1, brownout_ok_in = 1'b1;
    logic brownout_detect_en_in = 1'b0, external_reset_pin_select_in = 1'b1;
    logic watchdog_timeout_in = 1'b0, sleep_in = 1'b0, prog_mode_in = 1'b0;
    logic prog_rd_in = 1'b0, prog_trim_wr_in = 1'b0, prog_erase_in = 1'b0;
    logic [13:0] prog_addr_in = 14'h0000, prog_wdata_in = 14'h0000, prog_rdata_out, tv;
    logic prog_rvalid_out, core_reset_out, wake_out, pin_pullup_en_out;
    logic pin_drive_out, pin_drive_en_out;
    wire logic external_reset_pin_in;
    rstc_trim_s trim_out;
    rstc_flags_s flags_out;
    rstc_cause_e cause_out;
    int num_errors = 0, checks_done = 0, i;
    logic [13:0] exp_q[$];
    logic [15:0] rnd = 16'hB893;
    always #12.5 clk_in = !clk_in;
    rstc_core dut (.clk_in, .arst_n_in, .supply_ok_in, .brownout_ok_in,
        .brownout_detect_en_in, .external_reset_pin_in, .external_reset_pin_select_in,
        .watchdog_timeout_in, .sleep_in, .prog_mode_in, .prog_addr_in, .prog_rd_in,
        .prog_trim_wr_in, .prog_erase_in, .prog_wdata_in, .prog_rdata_out,
        .prog_rvalid_out, .trim_out, .flags_out, .cause_out, .core_reset_out, .wake_out,
        .pin_pullup_en_out, .pin_drive_out, .pin_drive_en_out);
    rstc_pin_model u_pin (.supply_ok_in, .pin_out(external_reset_pin_in));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task conclude;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task wt(input logic v);
        for (i = 0; i < 200 && core_reset_out !== v; i++) @(negedge clk_in);
        chk("core_reset", 16'(v), 16'(core_reset_out));
    endtask
    // Op bits: expect answer, read, write, erase
    task acc(input logic [3:0] op, input logic [13:0] a, input logic [13:0] e);
        @(negedge clk_in);
        {prog_rd_in, prog_trim_wr_in, prog_erase_in} = op[2:0];
        prog_addr_in = a;
        prog_wdata_in = e;
        if (op[3]) exp_q.push_back(e);
        @(negedge clk_in);
        {prog_rd_in, prog_trim_wr_in, prog_erase_in} = 3'h0;
    endtask
    task pulse_wdt;
        watchdog_timeout_in = 1'b1;
        cyc(1);
        watchdog_timeout_in = 1'b0;
    endtask
    always @(negedge clk_in) begin
        if (prog_rvalid_out !== 1'b0) begin
            if (exp_q.size() == 0) chk("read answer", 16'h0, 16'h1);
            else chk("read data", 16'(exp_q.pop_front()), 16'(prog_rdata_out));
        end
    end
    initial begin
        #(25 * 4000);
        num_errors++;
        conclude();
    end
    initial begin
        cyc(10);
        chk("flags", 16'h0003, 16'(flags_out));
        arst_n_in = 1'b1;
        wt(1'b0);
        prog_mode_in = 1'b1;
        cyc(4);
        repeat (4) begin
            rnd = lfsr_next(rnd);
            tv = rnd[13:0] & 14'h1FDF;
            acc(4'h2, RSTC_TRIM_ADDR, rnd[13:0]);
            acc(4'hC, RSTC_TRIM_ADDR, tv);
        end
        acc(4'h3, RSTC_TRIM_ADDR, ~tv);
        acc(4'h1, RSTC_TRIM_ADDR, ~tv);
        acc(4'hC, RSTC_TRIM_ADDR, tv);
        acc(4'h4, {1'b0, rnd[12:0]}, ~rnd[13:0]);
        prog_mode_in = 1'b0;
        cyc(4);
        acc(4'h4, RSTC_TRIM_ADDR, 14'h0000);
        acc(4'h2, RSTC_TRIM_ADDR, ~tv);
        rnd = lfsr_next(rnd);
        u_pin.press(1'b1);
        cyc(20 + int'(rnd[4:0]));
        u_pin.press(1'b0);
        cyc(10);
        chk("glitch", 16'h0, 16'(core_reset_out));
        u_pin.press(1'b1);
        wt(1'b1);
        chk("cause", 16'(RSTC_CAUSE_PIN_RUN), 16'(cause_out));
        chk("flags", 16'h0003, 16'(flags_out));
        u_pin.press(1'b0);
        wt(1'b0);
        sleep_in = 1'b1;
        cyc(3);
        u_pin.press(1'b1);
        wt(1'b1);
        chk("cause", 16'(RSTC_CAUSE_PIN_SLEEP), 16'(cause_out));
        chk("flags", 16'h0002, 16'(flags_out));
        sleep_in = 1'b0;
        u_pin.press(1'b0);
        wt(1'b0);
        sleep_in = 1'b1;
        cyc(3);
        pulse_wdt();
        for (i = 0; i < 10 && wake_out !== 1'b1; i++) @(negedge clk_in);
        chk("wake", 16'h1, 16'(wake_out));
        chk("core_reset", 16'h0, 16'(core_reset_out));
        cyc(3);
        chk("flags", 16'h0000, 16'(flags_out));
        sleep_in = 1'b0;
        cyc(3);
        pulse_wdt();
        wt(1'b1);
        chk("cause", 16'(RSTC_CAUSE_WDT_RUN), 16'(cause_out));
        chk("flags", 16'h0000, 16'(flags_out));
        chk("pin drive", 16'h0, 16'(pin_drive_en_out));
        wt(1'b0);
        supply_ok_in = 1'b0;
        wt(1'b1);
        chk("cause", 16'(RSTC_CAUSE_POR), 16'(cause_out));
        chk("flags", 16'h0003, 16'(flags_out));
        supply_ok_in = 1'b1;
        wt(1'b0);
        {brownout_detect_en_in, brownout_ok_in} = 2'b10;
        wt(1'b1);
        chk("cause", 16'(RSTC_CAUSE_BOD), 16'(cause_out));
        brownout_ok_in = 1'b1;
        wt(1'b0);
        external_reset_pin_select_in = 1'b0;
        cyc(3);
        u_pin.press(1'b1);
        cyc(120);
        chk("tied reset", 16'h0, 16'(core_reset_out));
        chk("pull-up", 16'h1, 16'(pin_pullup_en_out));
        u_pin.press(1'b0);
        prog_mode_in = 1'b1;
        cyc(4);
        acc(4'hC, RSTC_TRIM_ADDR, tv);
        cyc(3);
        arst_n_in = 1'b0;
        cyc(3);
        chk("core_reset", 16'h1, 16'(core_reset_out));
        chk("cause", 16'(RSTC_CAUSE_POR), 16'(cause_out));
        chk("flags", 16'h0003, 16'(flags_out));
        arst_n_in = 1'b1;
        wt(1'b0);
        cyc(4);
        acc(4'hC, RSTC_TRIM_ADDR, tv);
        cyc(3);
        conclude();
    end
endmodule
